/* File: rtl/acc_pkg.sv */
// package: register map, field layout and timing constants for the conversion control block
package acc_pkg;
  // register byte addresses (chosen, word aligned)
  localparam logic [7:0] ADDR_STATUS_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO    = 8'h04;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h0C;
  localparam logic [7:0] ADDR_CMP_HIGH    = 8'h10;
  localparam logic [7:0] ADDR_CMP_LOW     = 8'h14;
  localparam logic [7:0] ADDR_CONFIG      = 8'h18;
  // conversion_status_control fields
  localparam int          BIT_DONE     = 7;
  localparam int          BIT_IRQ_EN   = 6;
  localparam int          BIT_CONT     = 5;
  // control two fields
  localparam int          BIT_ACTIVE   = 7;
  localparam int          BIT_TRIG_HW  = 6;
  localparam int          BIT_CMP_EN   = 5;
  localparam int          BIT_CMP_GE   = 4;
  // config fields
  localparam int          BIT_MODE10   = 2;
  localparam int          CLKSEL_LSB   = 0;
  localparam logic [4:0]  CH_OFF       = 5'h1F;
  localparam logic [4:0]  CH_RESERVED  = 5'h1C;
  localparam logic [4:0]  CH_REF_HIGH  = 5'h1D;
  localparam logic [4:0]  CH_REF_LOW   = 5'h1E;
  localparam logic [4:0]  CH_LAST_IN   = 5'h1B;
  localparam logic [4:0]  CH_RESET     = 5'h1F;
  localparam int          RES_BITS     = 10;
  localparam logic [3:0]  BIT_CNT_TOP  = 4'h9;
  localparam logic [9:0]  SAR_MID      = 10'h200;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_RESOLVE} acc_state_e;
endpackage

/* File: rtl/acc_clk_div.sv */
// conversion clock source select and tick generator
module acc_clk_div
  import acc_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_sel,
  input  wire logic       i_alt_tick,
  input  wire logic       i_async_tick,
  output logic            o_tick
);
  logic half_reg;
  logic tick_reg;
  logic tick_next;

  // four sources: bus clock, bus/2, alternate, local asynchronous
  always_comb begin
    unique case (i_sel)
      2'h0: tick_next = 1'b1;
      2'h1: tick_next = half_reg;
      2'h2: tick_next = i_alt_tick;
      2'h3: tick_next = i_async_tick;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      half_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg;
endmodule // acc_clk_div

/* File: rtl/acc_conv_ctrl.sv */
// conversion control: ahb-lite registers, triggering, sar sequence, result and compare
module acc_conv_ctrl
  import acc_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        i_hw_trigger_in,
  input  wire logic        i_alt_clk_tick,
  input  wire logic        i_async_clk_tick,
  input  wire logic        i_comparator_hi,
  output logic [4:0]       o_input_channel_select,
  output logic             o_conv_on,
  output logic             o_sample,
  output logic [9:0]       o_sar_trial,
  output logic             o_conv_irq
);
  // bus address phase capture
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // registers
  logic [7:0]  sc1_reg;
  logic [7:0]  sc2_reg;
  logic [9:0]  cmp_reg;
  logic [2:0]  cfg_reg;
  logic [9:0]  result_reg;
  logic        locked_reg;
  logic        done_reg;
  logic        irq_reg;
  logic        active_reg;

  // conversion engine
  acc_state_e  state_reg;
  logic [3:0]  bit_reg;
  logic [9:0]  sar_reg;
  logic [9:0]  trial_reg;
  logic        hw_meta_reg;
  logic        hw_sync_reg;
  logic        hw_prev_reg;
  logic        tick;

  wire         addr_ok     = hsel & hready & htrans[1];
  wire         wr_sc1      = wr_pend_reg & reg_hit(addr_reg, ADDR_STATUS_CTRL);
  wire         wr_sc2      = wr_pend_reg & reg_hit(addr_reg, ADDR_CTRL_TWO);
  wire         wr_cmp_h    = wr_pend_reg & reg_hit(addr_reg, ADDR_CMP_HIGH);
  wire         wr_cmp_l    = wr_pend_reg & reg_hit(addr_reg, ADDR_CMP_LOW);
  wire         wr_cfg      = wr_pend_reg & reg_hit(addr_reg, ADDR_CONFIG);
  wire         rd_low      = rd_pend_reg & reg_hit(addr_reg, ADDR_RESULT_LOW);
  wire         rd_high     = rd_pend_reg & reg_hit(addr_reg, ADDR_RESULT_HIGH);
  wire [4:0]   wr_chan     = hwdata[4:0];
  wire         chan_off    = (sc1_reg[4:0] == CH_OFF);
  wire         mode10      = cfg_reg[BIT_MODE10];
  wire         hw_mode     = sc2_reg[BIT_TRIG_HW];
  wire         continuous  = sc1_reg[BIT_CONT];
  wire         hw_event    = hw_sync_reg & ~hw_prev_reg;
  // software start on a write with a live channel code
  wire         write_start = wr_sc1 & (wr_chan != CH_OFF) & ~hw_mode;
  wire         trig_start  = hw_mode & hw_event & ~chan_off & ~wr_sc1;
  wire         last_bit    = (state_reg == ACC_RESOLVE) & tick & (bit_reg == 4'h0);
  wire [9:0]   final_code  = comparator_apply(sar_reg, trial_reg, i_comparator_hi);
  wire [9:0]   fmt_code    = mode10 ? final_code : {2'h0, final_code[9:2]};
  wire [9:0]   cmp_value   = mode10 ? cmp_reg : {2'h0, cmp_reg[7:0]};
  wire         cmp_true    = sc2_reg[BIT_CMP_GE] ? (fmt_code >= cmp_value)
                                                 : (fmt_code < cmp_value);
  wire         qualified   = ~sc2_reg[BIT_CMP_EN] | cmp_true;
  wire         complete    = last_bit & ~wr_sc1;
  wire         commit      = complete & qualified & ~(mode10 & locked_reg);
  wire         restart     = complete & continuous & ~chan_off;
  // the comparator judges what is shown, so show the trial of the coming tick
  wire [9:0]   trial_show  = (state_reg == ACC_SAMPLE) ? SAR_MID
                           : ((state_reg == ACC_RESOLVE) & tick) ? (final_code | (trial_reg >> 1))
                           : (sar_reg | trial_reg);

  // keep trial bit when comparator says input is above it
  function automatic logic [9:0] comparator_apply(input logic [9:0] acc,
                                                  input logic [9:0] trial,
                                                  input logic       above);
    comparator_apply = above ? (acc | trial) : acc;
  endfunction

  // register decode shared by every write and read strobe
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] target);
    reg_hit = (addr == target);
  endfunction

  // clock select kept in a small leaf so all sources yield one enable tick
  acc_clk_div u_clk (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_sel       (cfg_reg[CLKSEL_LSB +: 2]),
    .i_alt_tick  (i_alt_clk_tick),
    .i_async_tick(i_async_clk_tick),
    .o_tick      (tick)
  );

  // bus address phase
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      rd_pend_reg <= addr_ok & ~hwrite;
      addr_reg    <= haddr[7:0];
    end
  end

  // read mux in address phase, registered for the data phase
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (haddr[7:0])
      ADDR_STATUS_CTRL: rdata_next[7:0] = {done_reg, sc1_reg[6:0]};
      ADDR_CTRL_TWO:    rdata_next[7:0] = {active_reg, sc2_reg[6:4], 4'h0};
      ADDR_RESULT_HIGH: rdata_next[7:0] = {6'h00, result_reg[9:8]};
      ADDR_RESULT_LOW:  rdata_next[7:0] = result_reg[7:0];
      ADDR_CMP_HIGH:    rdata_next[7:0] = {6'h00, cmp_reg[9:8]};
      ADDR_CMP_LOW:     rdata_next[7:0] = cmp_reg[7:0];
      ADDR_CONFIG:      rdata_next[7:0] = {5'h00, cfg_reg};
      default:          rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (addr_ok & ~hwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  // software registers
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sc1_reg <= {3'h0, CH_RESET};
      sc2_reg <= 8'h00;
      cmp_reg <= 10'h000;
      cfg_reg <= 3'h0;
    end else begin
      if (wr_sc1) sc1_reg <= {1'b0, hwdata[6:0]};
      if (wr_sc2) sc2_reg <= {1'b0, hwdata[6:4], 4'h0};
      if (wr_cmp_h) cmp_reg[9:8] <= hwdata[1:0];
      if (wr_cmp_l) cmp_reg[7:0] <= hwdata[7:0];
      if (wr_cfg) cfg_reg <= hwdata[2:0];
    end
  end

  // result commit; a blocked pair simply loses the new value
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      result_reg <= 10'h000;
    end else if (commit) begin
      result_reg <= fmt_code;
    end
  end

  // interlock only in ten-bit mode, dropped when the mode leaves it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      locked_reg <= 1'b0;
    end else if (rd_high & mode10) begin
      locked_reg <= 1'b1;
    end else if (rd_low | ~mode10) begin
      locked_reg <= 1'b0;
    end
  end

  // completion is masked on a status write; a low read in the commit cycle loses
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      done_reg <= 1'b0;
    end else if (commit) begin
      done_reg <= 1'b1;
    end else if (wr_sc1 | rd_low) begin
      done_reg <= 1'b0;
    end
  end

  // interrupt is a level that follows the flag while enabled
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else if (commit) begin
      irq_reg <= sc1_reg[BIT_IRQ_EN];
    end else if (wr_sc1 | rd_low) begin
      irq_reg <= 1'b0;
    end else if (~sc1_reg[BIT_IRQ_EN]) begin
      irq_reg <= 1'b0;
    end
  end

  // hardware trigger synchroniser
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hw_meta_reg <= 1'b0;
      hw_sync_reg <= 1'b0;
      hw_prev_reg <= 1'b0;
    end else begin
      hw_meta_reg <= i_hw_trigger_in;
      hw_sync_reg <= hw_meta_reg;
      hw_prev_reg <= hw_sync_reg;
    end
  end

  // sar engine: sample one tick, then ten trial ticks msb first
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ACC_IDLE;
      bit_reg   <= 4'h0;
      sar_reg   <= 10'h000;
      trial_reg <= 10'h000;
    end else if (write_start | trig_start) begin
      state_reg <= ACC_SAMPLE;
    end else if (wr_sc1) begin
      state_reg <= ACC_IDLE;
    end else begin
      unique case (state_reg)
        ACC_IDLE: state_reg <= ACC_IDLE;
        ACC_SAMPLE: begin
          if (tick) begin
            state_reg <= ACC_RESOLVE;
            bit_reg   <= BIT_CNT_TOP;
            sar_reg   <= 10'h000;
            trial_reg <= SAR_MID;
          end
        end
        ACC_RESOLVE: begin
          if (tick) begin
            sar_reg   <= final_code;
            trial_reg <= trial_reg >> 1;
            bit_reg   <= bit_reg - 4'h1;
            if (bit_reg == 4'h0) begin
              // single mode drops to idle, continuous resamples
              state_reg <= restart ? ACC_SAMPLE : ACC_IDLE;
            end
          end
        end
        default: state_reg <= ACC_IDLE;
      endcase
    end
  end

  // active flag: set on start, dropped on abort or on a finish without restart
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      active_reg <= 1'b0;
    end else if (write_start | trig_start) begin
      active_reg <= 1'b1;
    end else if (wr_sc1) begin
      active_reg <= 1'b0;
    end else if (last_bit) begin
      active_reg <= restart;
    end else if (state_reg == ACC_IDLE) begin
      active_reg <= 1'b0;
    end
  end

  // analog-facing outputs
  logic [4:0] chan_out_reg;
  logic       on_reg;
  logic       sample_reg;
  logic [9:0] trial_out_reg;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      chan_out_reg  <= CH_RESET;
      on_reg        <= 1'b0;
      sample_reg    <= 1'b0;
      trial_out_reg <= 10'h000;
    end else begin
      chan_out_reg  <= sc1_reg[4:0];
      on_reg        <= (state_reg != ACC_IDLE) & ~chan_off;
      sample_reg    <= (state_reg == ACC_SAMPLE);
      trial_out_reg <= trial_show;
    end
  end

  // bus response kept in flops so every output leaves a register; zero wait, always okay
  logic       ready_reg;
  logic       resp_reg;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ready_reg <= 1'b1;
      resp_reg  <= 1'b0;
    end else begin
      ready_reg <= 1'b1;
      resp_reg  <= 1'b0;
    end
  end

  assign o_input_channel_select = chan_out_reg;
  assign o_conv_on              = on_reg;
  assign o_sample               = sample_reg;
  assign o_sar_trial            = trial_out_reg;
  assign o_conv_irq             = irq_reg;
  assign hrdata                 = rdata_reg;
  assign hreadyout              = ready_reg;
  assign hresp                  = resp_reg;
endmodule // acc_conv_ctrl

/* File: sim/acc_partner.sv */
// partner: periodic wake-up counter trigger and comparator model
module acc_partner
  import acc_pkg::*;
#(
  parameter int CNT_W = 6
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [9:0] i_level,
  input  wire logic [9:0] i_trial,
  output logic            o_trigger,
  output logic            o_cmp_hi
);
  logic [CNT_W-1:0] cnt_reg;
  // free running while enabled, one-cycle pulse at each overflow
  // bench clock stands in for the reference or slow internal counter clock
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg   <= '0;
      o_trigger <= 1'b0;
    end else begin
      cnt_reg   <= i_run ? cnt_reg + 1'b1 : '0;
      o_trigger <= i_run && (&cnt_reg);
    end
  end
  // half-lsb offset so a tie resolves to the exact code
  assign o_cmp_hi = {i_level, 1'b1} > {i_trial, 1'b0};
endmodule // acc_partner

/* File: sim/acc_conv_ctrl_assertions.sv */
// checker: port-level relations of the conversion control block
module acc_conv_ctrl_assertions
  import acc_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic [4:0]  o_input_channel_select,
  input wire logic        o_conv_on,
  input wire logic        o_sample,
  input wire logic [9:0]  o_sar_trial,
  input wire logic        o_conv_irq
);
  logic       wr_reg;
  logic [4:0] ch_reg;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_reg <= 1'b0;
      ch_reg <= CH_RESET;
    end else begin
      wr_reg <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == ADDR_STATUS_CTRL);
      ch_reg <= wr_reg ? hwdata[4:0] : ch_reg;
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_wr; wr_reg; endsequence
  sequence s_off; wr_reg && hwdata[4:0] == CH_OFF; endsequence
  property p_hi0; hrdata[31:8] == 24'h0; endproperty
  a_hi0: assert property (p_hi0) else $error("read data upper bits set");
  property p_ch; s_wr |=> ##[0:1] o_input_channel_select == ch_reg; endproperty
  a_ch: assert property (p_ch) else $error("channel not copied");
  property p_off; s_off |-> ##[1:3] !o_conv_on; endproperty
  a_off: assert property (p_off) else $error("off write kept converter on");
  property p_stay; (o_input_channel_select == CH_OFF) [*2] |-> !o_conv_on; endproperty
  a_stay: assert property (p_stay) else $error("converter on while off");
  property p_clr; s_wr |=> ##[0:1] !o_conv_irq; endproperty
  a_clr: assert property (p_clr) else $error("irq survived status write");
  property p_irq; $rose(o_conv_irq) |-> $past(o_conv_on) && !o_sample; endproperty
  a_irq: assert property (p_irq) else $error("irq without completion");
  property p_mid; $rose(o_sample) && o_conv_on |-> o_sar_trial == SAR_MID; endproperty
  a_mid: assert property (p_mid) else $error("first trial not midscale");
  property p_smp; o_sample |-> o_conv_on; endproperty
  a_smp: assert property (p_smp) else $error("sampling while off");
endmodule // acc_conv_ctrl_assertions

bind acc_conv_ctrl acc_conv_ctrl_assertions u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .o_input_channel_select(o_input_channel_select),
  .o_conv_on(o_conv_on), .o_sample(o_sample), .o_sar_trial(o_sar_trial),
  .o_conv_irq(o_conv_irq));

/* File: sim/test_acc_conv_ctrl.sv */
// testbench: register-level scenarios for the conversion control block
module test_acc_conv_ctrl
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys, hrdy, hresp, trig, cmp_hi, on, smp, irq;
  logic        i_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
  logic        alt = 1'b0, asy = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [9:0]  level = 10'h0, trial;
  logic [4:0]  ch;
  int          n_errors = 0, check_count = 0;

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) {alt, asy} <= {~alt, alt};

  acc_conv_ctrl dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .i_hw_trigger_in(trig),
    .i_alt_clk_tick(alt), .i_async_clk_tick(asy), .i_comparator_hi(cmp_hi),
    .o_input_channel_select(ch), .o_conv_on(on), .o_sample(smp), .o_sar_trial(trial),
    .o_conv_irq(irq));
  acc_partner u_far (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_run(run), .i_level(level),
    .i_trial(trial), .o_trigger(trig), .o_cmp_hi(cmp_hi));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge i_clk_sys); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk_sys); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  // with exp 0 the full bound passes, proving no completion was flagged
  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    // let a clear launched at the caller's last edge land first
    @(posedge i_clk_sys);
    while (irq !== 1'b1 && n < 300) begin
      @(posedge i_clk_sys);
      n++;
    end
    chk(32'(irq), 32'(exp));
  endtask

  task automatic t_reset;
    bus(1'b0, ADDR_STATUS_CTRL, 32'h0);
    chk(rd, 32'h1F);
    chk(32'(ch), 32'(CH_RESET));
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
  endtask
  task automatic t_single;
    level <= 10'h2A5;
    bus(1'b1, ADDR_CONFIG, 32'h04);
    bus(1'b1, ADDR_STATUS_CTRL, 32'h43);
    bus(1'b0, ADDR_CTRL_TWO, 32'h0);
    chk(rd, 32'h80);
    wait_irq(1'b1);
    bus(1'b0, ADDR_STATUS_CTRL, 32'h0);
    chk(rd, 32'hC3);
    chk(32'(on), 32'h0);
    bus(1'b0, ADDR_RESULT_HIGH, 32'h0);
    chk(rd, 32'h2);
    level <= 10'h155;
    bus(1'b1, ADDR_STATUS_CTRL, 32'h43);
    wait_irq(1'b0);
    bus(1'b0, ADDR_RESULT_LOW, 32'h0);
    chk(rd, 32'hA5);
    bus(1'b0, ADDR_STATUS_CTRL, 32'h0);
    chk(rd, 32'h43);
    bus(1'b1, ADDR_STATUS_CTRL, 32'h43);
    wait_irq(1'b1);
    bus(1'b0, ADDR_RESULT_LOW, 32'h0);
    chk(rd, 32'h55);
  endtask
  task automatic t_compare;
    bus(1'b1, ADDR_CONFIG, 32'h07);
    bus(1'b1, ADDR_CMP_HIGH, 32'h1);
    bus(1'b1, ADDR_CMP_LOW, 32'h0);
    bus(1'b1, ADDR_CTRL_TWO, 32'h20);
    bus(1'b1, ADDR_STATUS_CTRL, 32'h43);
    wait_irq(1'b0);
    bus(1'b1, ADDR_CTRL_TWO, 32'h30);
    bus(1'b1, ADDR_STATUS_CTRL, 32'h43);
    wait_irq(1'b1);
    bus(1'b0, ADDR_RESULT_LOW, 32'h0);
    chk(rd, 32'h55);
  endtask
  task automatic t_hw;
    bus(1'b1, ADDR_CONFIG, 32'h06);
    bus(1'b1, ADDR_CTRL_TWO, 32'h40);
    bus(1'b1, ADDR_STATUS_CTRL, 32'h43);
    repeat (30) @(posedge i_clk_sys);
    chk(32'(on), 32'h0);
    run <= 1'b1;
    wait_irq(1'b1);
    run <= 1'b0;
    bus(1'b0, ADDR_RESULT_LOW, 32'h0);
    @(posedge i_clk_sys);
    chk(32'(irq), 32'h0);
    chk(32'(on), 32'h0);
  endtask
  task automatic t_cont;
    level <= 10'h2A5;
    bus(1'b1, ADDR_CTRL_TWO, 32'h0);
    bus(1'b1, ADDR_CONFIG, 32'h01);
    bus(1'b1, ADDR_STATUS_CTRL, 32'h65);
    wait_irq(1'b1);
    bus(1'b0, ADDR_RESULT_LOW, 32'h0);
    chk(rd, 32'hA9);
    wait_irq(1'b1);
    bus(1'b1, ADDR_STATUS_CTRL, 32'h7F);
    repeat (60) @(posedge i_clk_sys);
    chk(32'(on), 32'h0);
    chk(32'(irq), 32'h0);
    bus(1'b0, ADDR_RESULT_HIGH, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #800us;
    n_errors++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_reset;
    t_single;
    t_compare;
    t_hw;
    t_cont;
    conclude;
  end
endmodule // test_acc_conv_ctrl
